// ### rtl/nsx_alu.sv
// Purpose: Combinational result and zero flag for the four operations.
// Assumes: Operands are stable for the cycle in which they are used.
// Notes:   No state; the core registers everything.
`timescale 1ns/1ps
module nsx_alu (
  nsx_alu_if.alu bus
);

  // Computes the result; only the xor forms touch the zero flag.
  always_comb
  begin
    bus.result = bus.acc;
    bus.upd_z  = 1'b0;
    unique case (bus.op)
      nsx_pkg::NSX_OP_SWAP:
      begin
        // Halves exchange, flags untouched.
        bus.result = {bus.fdata[3:0], bus.fdata[7:4]};
      end
      nsx_pkg::NSX_OP_XORF:
      begin
        // Accumulator xor file register.
        bus.result = bus.acc ^ bus.fdata;
        bus.upd_z  = 1'b1;
      end
      nsx_pkg::NSX_OP_XORL:
      begin
        // Accumulator xor literal.
        bus.result = bus.acc ^ bus.lit;
        bus.upd_z  = 1'b1;
      end
      nsx_pkg::NSX_OP_DIR:
      begin
        // The accumulator passes through to the direction register.
        bus.result = bus.acc;
      end
      nsx_pkg::NSX_OP_NONE:
      begin
        // Nothing to compute.
        bus.result = bus.acc;
      end
      default:
      begin
        // Codes outside the set compute nothing.
        bus.result = bus.acc;
      end
    endcase
    // Zero flag follows an all-zero result.
    bus.zero = (bus.result == 8'h00);
  end

endmodule // nsx_alu

// ### rtl/nsx_alu_if.sv
// Purpose: Carries one decoded operation and its result between the
//          execute core and the arithmetic unit.
// Assumes: Purely combinational traffic within one clock cycle.
// Notes:   The core drives operands, the unit answers.
`timescale 1ns/1ps
interface nsx_alu_if;
  nsx_pkg::nsx_op_e op;      // Operation to perform.
  logic [7:0]       acc;     // Accumulator operand.
  logic [7:0]       fdata;   // Addressed file register operand.
  logic [7:0]       lit;     // Eight-bit literal operand.
  logic [7:0]       result;  // Result of the operation.
  logic             upd_z;   // High when the zero flag is updated.
  logic             zero;    // New zero flag value.

  // Core side drives operands.
  modport core (output op, acc, fdata, lit, input result, upd_z, zero);
  // Unit side computes the result.
  modport alu (input op, acc, fdata, lit, output result, upd_z, zero);
endinterface

// ### rtl/nsx_exec.sv
// Purpose: Decodes and executes nibble swap, xor literal, xor file and
//          direction load instructions, one per clock.
// Assumes: Instructions arrive from logic on sys_clk with instr_valid.
// Notes:   The file registers are held here; direction registers sit at
//          their own file addresses so both paths reach them.
`timescale 1ns/1ps

module nsx_exec #(
  parameter int unsigned FILE_DEPTH = 128
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic [6:0]  peek_addr,
  output logic      [7:0]  acc_out,
  output logic             zero_out,
  output logic      [23:0] dir_out,
  output logic      [7:0]  peek_data,
  output logic             done_out,
  output logic             bad_out
);

  // The file must cover every seven-bit address.
  if (FILE_DEPTH < 128)
  begin : g_depth_check
    $error("FILE_DEPTH must be at least 128");
  end

  // State registers and their next values.
  logic [7:0] acc_q, acc_d;                  // Working accumulator.
  logic       zero_q, zero_d;                // Zero flag.
  logic       done_q, done_d;                // Executed pulse.
  logic       bad_q, bad_d;                  // Unknown opcode pulse.
  logic [7:0] peek_q, peek_d;                // Registered read port.
  logic [7:0] file_q [FILE_DEPTH];           // File registers.
  logic [7:0] file_d [FILE_DEPTH];           // Their next values.

  // Decode signals.
  logic [1:0] grp;                           // Opcode group.
  logic [3:0] opc;                           // Function code.
  logic [6:0] faddr;                         // File address field.
  logic       dest;                          // Destination bit.
  logic [2:0] dsel;                          // Direction selector.
  logic [7:0] fdata;                         // Addressed file data.
  logic       file_wr;                       // Result goes to the file.
  logic [6:0] wr_addr;                       // File write address.
  nsx_pkg::nsx_op_e op;                      // Decoded operation.

  // Link to the arithmetic unit.
  nsx_alu_if alu_bus ();

  nsx_alu u_alu (
    .bus (alu_bus)
  );

  assign grp   = instr[nsx_pkg::GRP_HI:nsx_pkg::GRP_LO];
  assign opc   = instr[nsx_pkg::OPC_HI:nsx_pkg::OPC_LO];
  assign dest  = instr[nsx_pkg::DEST_BIT];
  assign faddr = instr[6:0];
  assign dsel  = instr[2:0];
  assign fdata = file_q[faddr];

  // Operands for the arithmetic unit.
  assign alu_bus.op    = op;
  assign alu_bus.acc   = acc_q;
  assign alu_bus.fdata = fdata;
  assign alu_bus.lit   = instr[7:0];

  // Decodes the instruction word into one operation.
  always_comb
  begin
    op = nsx_pkg::NSX_OP_NONE;
    if (instr_valid)
    begin
      if (instr[13:nsx_pkg::DIR_LO] == nsx_pkg::OPC_DIR &&
          dsel >= nsx_pkg::DIR_FIRST)
      begin
        // Only selectors five to seven are direction registers.
        op = nsx_pkg::NSX_OP_DIR;
      end
      else if (grp == nsx_pkg::GRP_FILE && opc == nsx_pkg::OPC_SWAP)
      begin
        op = nsx_pkg::NSX_OP_SWAP;
      end
      else if (grp == nsx_pkg::GRP_FILE && opc == nsx_pkg::OPC_XORF)
      begin
        op = nsx_pkg::NSX_OP_XORF;
      end
      else if (grp == nsx_pkg::GRP_LIT && opc == nsx_pkg::OPC_XORL)
      begin
        op = nsx_pkg::NSX_OP_XORL;
      end
    end
  end

  // Chooses where the result goes.
  always_comb
  begin
    file_wr = 1'b0;
    wr_addr = faddr;
    unique case (op)
      nsx_pkg::NSX_OP_SWAP, nsx_pkg::NSX_OP_XORF:
      begin
        // Destination one writes back to the file.
        file_wr = dest;
      end
      nsx_pkg::NSX_OP_DIR:
      begin
        // The selector doubles as the file address.
        file_wr = 1'b1;
        wr_addr = {4'h0, dsel};
      end
      default:
      begin
        file_wr = 1'b0;
      end
    endcase
  end

  // Next accumulator, flag, pulses and read port.
  always_comb
  begin
    acc_d  = acc_q;
    zero_d = zero_q;
    done_d = (op != nsx_pkg::NSX_OP_NONE);
    bad_d  = instr_valid && (op == nsx_pkg::NSX_OP_NONE);
    peek_d = file_q[peek_addr];
    if (op == nsx_pkg::NSX_OP_XORL)
    begin
      // Literal form always lands in the accumulator.
      acc_d = alu_bus.result;
    end
    else if ((op == nsx_pkg::NSX_OP_SWAP || op == nsx_pkg::NSX_OP_XORF)
             && !dest)
    begin
      // Destination zero selects the accumulator.
      acc_d = alu_bus.result;
    end
    if (alu_bus.upd_z)
    begin
      // Only the xor forms refresh the flag.
      zero_d = alu_bus.zero;
    end
  end

  // Next file contents: one entry may change per cycle.
  always_comb
  begin
    for (int i = 0; i < FILE_DEPTH; i++)
    begin
      file_d[i] = file_q[i];
    end
    if (file_wr)
    begin
      file_d[wr_addr] = alu_bus.result;
    end
  end

  // Registers the core state.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_q  <= nsx_pkg::ACC_RESET;
      zero_q <= 1'b0;
      done_q <= 1'b0;
      bad_q  <= 1'b0;
      peek_q <= nsx_pkg::FILE_RESET;
    end
    else
    begin
      acc_q  <= acc_d;
      zero_q <= zero_d;
      done_q <= done_d;
      bad_q  <= bad_d;
      peek_q <= peek_d;
    end
  end

  // One register per file entry; direction entries reset to all inputs.
  for (genvar g = 0; g < FILE_DEPTH; g++)
  begin : g_file
    // Entries inside the selector range come up as all inputs.
    localparam logic [7:0] RST_V =
      (g >= int'(nsx_pkg::DIR_FIRST) && g <= int'(nsx_pkg::DIR_LAST)) ?
      nsx_pkg::DIR_RESET : nsx_pkg::FILE_RESET;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        file_q[g] <= RST_V;
      end
      else
      begin
        file_q[g] <= file_d[g];
      end
    end
  end

  // Outputs come straight from registers.
  assign acc_out   = acc_q;
  assign zero_out  = zero_q;
  assign dir_out   = {file_q[7], file_q[6], file_q[5]};
  assign peek_data = peek_q;
  assign done_out  = done_q;
  assign bad_out   = bad_q;

  // Swap to the accumulator gives exchanged halves, flag held.
  a_swap_result: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (op == nsx_pkg::NSX_OP_SWAP && !dest) |=>
      acc_q == {$past(fdata[3:0]), $past(fdata[7:4])} &&
      $stable(zero_q))
    else $error("swap result or flag wrong");

  // Direction load lands in the selected register.
  a_dir_load: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (op == nsx_pkg::NSX_OP_DIR) |=>
      file_q[$past(dsel)] == $past(acc_q) && $stable(zero_q) &&
      $stable(acc_q))
    else $error("direction load wrong");

  // Xor literal result and flag.
  a_xor_literal: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (op == nsx_pkg::NSX_OP_XORL) |=>
      acc_q == ($past(acc_q) ^ $past(instr[7:0])) &&
      zero_q == (acc_q == 8'h00))
    else $error("xor literal result wrong");

  // Xor file to the file leaves the accumulator alone.
  a_xor_file: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (op == nsx_pkg::NSX_OP_XORF && dest) |=>
      file_q[$past(faddr)] == ($past(acc_q) ^ $past(fdata)) &&
      $stable(acc_q))
    else $error("xor file result wrong");

  // Destination zero leaves the file register alone.
  a_dest_acc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ((op == nsx_pkg::NSX_OP_SWAP || op == nsx_pkg::NSX_OP_XORF) && !dest)
      |=> file_q[$past(faddr)] == $past(fdata))
    else $error("file changed with destination zero");

  // Zero flag mirrors the file xor result, whichever destination is used.
  a_zero_flag: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (op == nsx_pkg::NSX_OP_XORF) |=>
      zero_q == (($past(acc_q) ^ $past(fdata)) == 8'h00))
    else $error("zero flag disagrees with result");

  // Every other word, refused ones included, leaves the flag alone.
  a_zero_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (op != nsx_pkg::NSX_OP_XORF && op != nsx_pkg::NSX_OP_XORL) |=>
      $stable(zero_q))
    else $error("zero flag changed without xor");

endmodule // nsx_exec

// ### rtl/nsx_pkg.sv
// Purpose: Shared constants and types for the nibble swap / xor / direction
//          load execute block.
// Assumes: A 14-bit instruction word and an 8-bit data path.
// Notes:   Every opcode and opcode field position, and the accumulator, file and direction reset values, live here; operand fields are cut in nsx_exec.
package nsx_pkg;

  // Widths of the instruction word, the data path and the file address.
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;

  // Field positions inside the instruction word.
  localparam int unsigned GRP_HI   = 13;
  localparam int unsigned GRP_LO   = 12;
  localparam int unsigned OPC_HI   = 11;
  localparam int unsigned OPC_LO   = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned DIR_LO   = 3;

  // Opcode group and function codes.
  localparam logic [1:0]  GRP_FILE = 2'h0;
  localparam logic [1:0]  GRP_LIT  = 2'h3;
  localparam logic [3:0]  OPC_SWAP = 4'hE;
  localparam logic [3:0]  OPC_XORF = 4'h6;
  localparam logic [3:0]  OPC_XORL = 4'hA;
  // Upper eleven bits of the direction-load word, selector in the low three.
  localparam logic [10:0] OPC_DIR  = 11'h00C;

  // Legal direction register selectors, which are also their file addresses.
  localparam logic [2:0] DIR_FIRST = 3'h5;
  localparam logic [2:0] DIR_LAST  = 3'h7;
  localparam int unsigned DIR_N    = 3;

  // Reset values: direction registers come up as all inputs.
  localparam logic [7:0] DIR_RESET  = 8'hFF;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET  = 8'h00;

  // Decoded operation handed to the arithmetic unit.
  typedef enum logic [2:0] {
    NSX_OP_NONE = 3'h0,
    NSX_OP_SWAP = 3'h1,
    NSX_OP_XORF = 3'h3,
    NSX_OP_XORL = 3'h2,
    NSX_OP_DIR  = 3'h6
  } nsx_op_e;

endpackage

// ### testbench/tb.sv
// Purpose: Self-checking bench for the nibble swap / xor / direction block.
// Assumes: Outputs settle at the edge that takes a word and are sampled at the next falling edge.
// Notes:   Each scenario leaves state that the next one builds upon.
`timescale 1ns/1ps
module tb;
  logic        sys_clk;      // System clock, 40 ns period.
  logic        rst_b;        // Asynchronous reset, active low.
  logic        instr_valid;  // Word present this cycle.
  logic [13:0] instr;        // Instruction word.
  logic [6:0]  peek_addr;    // File address to look at.
  logic [7:0]  acc_out;      // Accumulator.
  logic        zero_out;     // Zero flag.
  logic [23:0] dir_out;      // Direction registers 7, 6, 5.
  logic [7:0]  peek_data;    // Peeked file register.
  logic        done_out;     // Executed pulse.
  logic        bad_out;      // Refused pulse.
  int          mismatches;   // Failed comparisons.
  int          tests_run;    // Comparisons made.

  nsx_exec dut (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .instr_valid (instr_valid),
    .instr       (instr),
    .peek_addr   (peek_addr),
    .acc_out     (acc_out),
    .zero_out    (zero_out),
    .dir_out     (dir_out),
    .peek_data   (peek_data),
    .done_out    (done_out),
    .bad_out     (bad_out)
  );

  // The clock toggles every half period.
  always #20 sys_clk = ~sys_clk;

  // Compares a byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a single flag.
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  // Checks the architectural state seen at the ports.
  task automatic state(input logic [7:0] a, input logic z,
                       input logic [23:0] d);
    chk8(acc_out, a);
    chk1(zero_out, z);
    chk8(dir_out[7:0], d[7:0]);
    chk8(dir_out[15:8], d[15:8]);
    chk8(dir_out[23:16], d[23:16]);
  endtask

  // Issues one word and checks the completion pulses a cycle later.
  task automatic exec(input logic [13:0] w, input logic dn, input logic bd);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr       <= w;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(negedge sys_clk);
    chk1(done_out, dn);
    chk1(bad_out, bd);
  endtask

  // Reads a file register through the peek port.
  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    peek_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk8(peek_data, exp);
  endtask

  // Reset values while held and just after release.
  task automatic t_reset;
    @(negedge sys_clk);
    state(8'h00, 1'b0, 24'hFFFFFF);
    chk1(done_out, 1'b0);
    chk1(bad_out, 1'b0);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    peek(7'h05, 8'hFF);
  endtask

  // Literal xor, zero flag, and two words back to back.
  task automatic t_xorl;
    exec(14'h3AB5, 1'b1, 1'b0);
    state(8'hB5, 1'b0, 24'hFFFFFF);
    exec(14'h3AAF, 1'b1, 1'b0);
    state(8'h1A, 1'b0, 24'hFFFFFF);
    exec(14'h3A1A, 1'b1, 1'b0);
    state(8'h00, 1'b1, 24'hFFFFFF);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr       <= 14'h3A3C;
    @(posedge sys_clk);
    @(negedge sys_clk);
    state(8'h3C, 1'b0, 24'hFFFFFF);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(negedge sys_clk);
    state(8'h00, 1'b1, 24'hFFFFFF);
    chk1(done_out, 1'b1);
  endtask

  // File xor to either destination.
  task automatic t_xorf;
    exec(14'h3AB5, 1'b1, 1'b0);
    exec(14'h06A0, 1'b1, 1'b0);
    state(8'hB5, 1'b0, 24'hFFFFFF);
    peek(7'h20, 8'hB5);
    exec(14'h0620, 1'b1, 1'b0);
    state(8'h00, 1'b1, 24'hFFFFFF);
    peek(7'h20, 8'hB5);
  endtask

  // Nibble swap keeps the zero flag as it was.
  task automatic t_swap;
    exec(14'h0E20, 1'b1, 1'b0);
    state(8'h5B, 1'b1, 24'hFFFFFF);
    exec(14'h0EA0, 1'b1, 1'b0);
    state(8'h5B, 1'b1, 24'hFFFFFF);
    peek(7'h20, 8'h5B);
  endtask

  // Direction loads, a refused selector, then a file xor into a direction register.
  task automatic t_dir;
    exec(14'h0066, 1'b1, 1'b0);
    state(8'h5B, 1'b1, 24'hFF5BFF);
    exec(14'h0064, 1'b0, 1'b1);
    state(8'h5B, 1'b1, 24'hFF5BFF);
    exec(14'h0065, 1'b1, 1'b0);
    exec(14'h0067, 1'b1, 1'b0);
    state(8'h5B, 1'b1, 24'h5B5B5B);
    exec(14'h0687, 1'b1, 1'b0);
    state(8'h5B, 1'b1, 24'h005B5B);
    peek(7'h06, 8'h5B);
    exec(14'h06A1, 1'b1, 1'b0);
    state(8'h5B, 1'b0, 24'h005B5B);
    peek(7'h21, 8'h5B);
  endtask

  // Words outside the block change nothing.
  task automatic t_bad;
    exec(14'h3FFF, 1'b0, 1'b1);
    exec(14'h2000, 1'b0, 1'b1);
    exec(14'h006E, 1'b0, 1'b1);
    state(8'h5B, 1'b0, 24'h005B5B);
  endtask

  // Mid-run reset clears everything and the next word runs at once.
  task automatic t_rerun;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    t_reset;
    peek(7'h21, 8'h00);
    exec(14'h3A01, 1'b1, 1'b0);
    state(8'h01, 1'b0, 24'hFFFFFF);
  endtask

  // Prints the verdict and stops.
  task automatic results;
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    sys_clk     = 1'b0;
    rst_b       = 1'b0;
    instr_valid = 1'b0;
    instr       = 14'h0000;
    peek_addr   = 7'h00;
    mismatches  = 0;
    tests_run   = 0;
    repeat (9) @(posedge sys_clk);
    t_reset;
    t_xorl;
    t_xorf;
    t_swap;
    t_dir;
    t_bad;
    t_rerun;
    results;
  end

  // Cuts a hang short; the run needs about seventy cycles.
  initial
  begin
    #80000;
    mismatches++;
    results;
  end
endmodule // tb
